// File: hw/mrss_ramp_gen.sv
`timescale 1ns/1ps
// Summary of operation
// - Matching stop switch zeroes velocity, halts ramp
// - Rising position travels toward right switches
// - Stop event sets stop flag
// - Slowdown decelerates linearly to slowdown velocity
// - Slowdown during automatic ramp stops motor
// - Status read clears stop and slowdown flags
// - Sync edge starts parked command, latches position
// - Constant, linear and S-curve segments supported
// - Integrators advance only on ramp tick
// - Jerk integrates into acceleration until nominal
// - Acceleration top bits integrate into velocity
// - Skip additions that would pass nominal limit
// - Integrator inputs enter eight bits lower
// - Velocity drives one pulse per step
// - Parameter command: opcode, selector, value low-first
// - Target command: opcode, 24-bit position low-first
// - Automatic start opcode, selector none keeps parameters
// - Sequencer bytes decode enable and sine mode
// - Stop flag bit 12, slowdown bit 13
// - Stop and slowdown responses gated by enables
// - Tick is clock over two to divider+1
module mrss_ramp_gen #(
  parameter int POS_W = mrss_pkg::POS_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Switch and sync pins
  input wire logic left_limit_stop_n_i,
  input wire logic right_limit_stop_n_i,
  input wire logic left_decel_switch_n_i,
  input wire logic right_decel_switch_n_i,
  input wire logic sync_in_i,
  // Switch response enables
  input wire logic stop_en_i,
  input wire logic sld_en_i,
  // Command queue head
  input wire logic cmd_valid_i,
  input wire logic [mrss_pkg::CMD_W-1:0] cmd_data_i,
  input wire logic cmd_wait_sync_i,
  input wire logic cmd_copy_hold_i,
  input wire logic cmd_queue_preempt_i,
  output logic cmd_ready_o,
  // Sequencer configuration
  input wire logic [7:0] seq_cfg0_i,
  input wire logic [7:0] seq_cfg1_i,
  output logic seq_enable_o,
  output logic seq_sine_o,
  // Status
  input wire logic status_rd_i,
  output logic [mrss_pkg::STAT_W-1:0] status_o,
  output logic [mrss_pkg::PIN_W-1:0] input_status_o,
  // Motion
  output logic step_o,
  output logic dir_o,
  output logic [mrss_pkg::ACC_W-1:0] actvel_o,
  output logic [mrss_pkg::ACC_W-1:0] actacc_o,
  output logic [POS_W-1:0] pos_o,
  output logic [POS_W-1:0] hold_pos_o
);
  import mrss_pkg::*;

  // ****************************************
  // Constants and state
  // ****************************************
  localparam logic [TCNT_W:0] ONE_T = (TCNT_W+1)'(1);
  localparam logic [TCNT_W:0] TWO_T = (TCNT_W+1)'(2);
  localparam logic [TCNT_W-1:0] ONE_C = TCNT_W'(1);
  localparam logic [ACC_W-1:0] ONE_A = ACC_W'(1);
  localparam logic [POS_W-1:0] ONE_P = POS_W'(1);

  typedef struct packed {
    logic [PIN_W-1:0] pin_m;
    logic [PIN_W-1:0] pin_s;
    logic sync_prev;
    logic sld_prev;
    logic [TCNT_W-1:0] tcnt;
    logic [PD_W-1:0] pre_div;
    logic [PAR_W-1:0] jerk;
    logic [PAR_W-1:0] a_nom;
    logic [PAR_W-1:0] v_nom;
    logic [SLD_W-1:0] a_sld;
    logic [SLD_W-1:0] v_sld;
    logic [POS_W-1:0] pos_end;
    mrss_mode_t mode;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] vel;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] hold;
    logic stop_flag;
    logic sld_flag;
    logic a_reached;
    logic v_reached;
    logic p_reached;
    logic pend;
    logic [CMD_W-1:0] pend_cmd;
    logic pend_copy;
    logic seq_en;
    logic sine;
  } mrss_ramp_state_t;

  mrss_ramp_state_t st_r;
  mrss_ramp_state_t st_nxt;

  logic [PIN_W-1:0] pin_raw;
  logic [TCNT_W:0] mask_w;
  logic tick;
  logic vel_neg;
  logic vel_fwd;
  logic [ACC_W-1:0] vel_mag;
  logic stop_hit;
  logic sld_act;
  logic sld_rise;
  logic sync_rise;
  logic fire;
  logic pend_go;
  logic ex_v;
  logic [CMD_W-1:0] ex_cmd;
  logic ex_copy;
  logic [7:0] ex_op;
  logic [3:0] ex_sel;
  logic [15:0] ex_val;
  logic [PD_W-1:0] ex_pd;
  logic [ACC_W-1:0] acc_sum_w;
  logic acc_over;
  logic [ACC_W-1:0] sld_lim;

  // ****************************************
  // Helpers
  // ****************************************
  // Two's complement magnitude of an accumulator
  function automatic logic [ACC_W-1:0] mag(input logic [ACC_W-1:0] v);
    mag = v[ACC_W-1] ? (~v + ONE_A) : v;
  endfunction

  // Sign-extend a parameter into the low end of an accumulator
  function automatic logic [ACC_W-1:0] sext(input logic [PAR_W-1:0] x);
    sext = {{FRAC_W{x[PAR_W-1]}}, x};
  endfunction

  // True when a sum would pass the nominal magnitude
  function automatic logic over_lim(input logic [ACC_W-1:0] v, input logic [PAR_W-1:0] nom);
    over_lim = mag(v) > {1'h0, nom[PAR_W-2:0], FRAC_ZERO};
  endfunction

  // ****************************************
  // Pins, tick and event decode
  // ****************************************
  // Active-low switches inverted ahead of the synchroniser
  assign pin_raw[IN_SLD_R] = ~right_decel_switch_n_i;
  assign pin_raw[IN_SLD_L] = ~left_decel_switch_n_i;
  assign pin_raw[IN_STOP_R] = ~right_limit_stop_n_i;
  assign pin_raw[IN_STOP_L] = ~left_limit_stop_n_i;
  assign pin_raw[IN_SYNC] = sync_in_i;

  // Free counter; tick when the low divider+1 bits are all ones
  assign mask_w = (TWO_T << st_r.pre_div) - ONE_T;
  assign tick = (st_r.tcnt & mask_w[TCNT_W-1:0]) == mask_w[TCNT_W-1:0];

  // Direction of travel from the velocity sign
  assign vel_neg = st_r.vel[ACC_W-1];
  assign vel_fwd = !vel_neg && (st_r.vel != '0);
  assign vel_mag = mag(st_r.vel);

  // Stop acts only on the switch ahead of the motion
  assign stop_hit = stop_en_i && (
    (vel_fwd && st_r.pin_s[IN_STOP_R]) ||
    (vel_neg && st_r.pin_s[IN_STOP_L]));
  assign sld_act = sld_en_i && (st_r.pin_s[IN_SLD_R] || st_r.pin_s[IN_SLD_L]);
  assign sld_rise = sld_act && !st_r.sld_prev;
  assign sync_rise = st_r.pin_s[IN_SYNC] && !st_r.sync_prev;

  // Queue head handshake; a preempting sync-gated command replaces a parked one
  assign cmd_ready_o = !st_r.pend || cmd_queue_preempt_i;
  assign fire = cmd_valid_i && cmd_ready_o;
  assign pend_go = sync_rise && st_r.pend && !(fire && cmd_wait_sync_i);
  assign ex_v = pend_go || (fire && !cmd_wait_sync_i);
  assign ex_cmd = pend_go ? st_r.pend_cmd : cmd_data_i;
  assign ex_copy = pend_go ? st_r.pend_copy : cmd_copy_hold_i;
  assign ex_op = ex_cmd[B0 +: 8];
  assign ex_sel = ex_cmd[B1 +: 4];
  assign ex_val = {ex_cmd[B3 +: 8], ex_cmd[B2 +: 8]};
  assign ex_pd = ex_val[PD_W-1:0];

  // First integrator sum, input entering eight bits down
  assign acc_sum_w = st_r.acc + sext(st_r.jerk);
  assign acc_over = over_lim(acc_sum_w, st_r.a_nom);
  assign sld_lim = {1'h0, st_r.v_sld, FRAC_ZERO};

  // ****************************************
  // Step pulse generator
  // ****************************************
  mrss_step_gen #(
    .MAG_W(PAR_W)
  ) u_step (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .tick_i(tick),
    .vel_mag_i(vel_mag[ACC_W-1:FRAC_W]),
    .vel_dir_i(!vel_neg),
    .step_o(step_o),
    .dir_o(dir_o)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Later blocks override earlier ones; stop is applied last so it always wins
  always_comb begin
    logic [ACC_W-1:0] vel_sum;
    logic [ACC_W-1:0] acc_up;
    logic [ACC_W-1:0] dec;
    logic [ACC_W-1:0] a_sld_w;
    vel_sum = '0;
    acc_up = {st_r.a_nom, FRAC_ZERO};
    dec = '0;
    a_sld_w = {{(ACC_W-SLD_W){1'h0}}, st_r.a_sld};
    st_nxt = st_r;
    st_nxt.pin_m = pin_raw;
    st_nxt.pin_s = st_r.pin_m;
    st_nxt.sync_prev = st_r.pin_s[IN_SYNC];
    st_nxt.sld_prev = sld_act;
    st_nxt.tcnt = st_r.tcnt + ONE_C;
    st_nxt.seq_en = (seq_cfg0_i != SEQ_OFF_B) || (seq_cfg1_i != SEQ_OFF_B);
    st_nxt.sine = (seq_cfg0_i == SEQ_SINE_B0) && (seq_cfg1_i == SEQ_SINE_B1);

    // Park a sync-gated command until the sync edge
    if (fire && cmd_wait_sync_i) begin
      st_nxt.pend = 1'h1;
      st_nxt.pend_cmd = cmd_data_i;
      st_nxt.pend_copy = cmd_copy_hold_i;
    end else if (pend_go) begin
      st_nxt.pend = 1'h0;
    end

    // Integrator cascade, one step per ramp tick
    if (tick) begin
      case (st_r.mode)
        MRSS_SCURVE: begin
          if (acc_over) begin
            st_nxt.a_reached = 1'h1;
          end else begin
            st_nxt.acc = acc_sum_w;
          end
        end
        MRSS_AUTO: begin
          if (st_r.pos == st_r.pos_end) begin
            st_nxt.acc = '0;
            st_nxt.vel = '0;
            st_nxt.mode = MRSS_IDLE;
            st_nxt.p_reached = 1'h1;
          end else begin
            st_nxt.acc = (st_r.pos_end > st_r.pos) ? acc_up : (~acc_up + ONE_A);
          end
        end
        default: begin
        end
      endcase
      if (st_nxt.mode != MRSS_IDLE && st_nxt.mode != MRSS_CONST) begin
        vel_sum = st_r.vel + sext(st_nxt.acc[ACC_W-1:FRAC_W]);
        if (over_lim(vel_sum, st_r.v_nom)) begin
          st_nxt.v_reached = 1'h1;
        end else begin
          st_nxt.vel = vel_sum;
        end
      end
    end

    // Command execution, immediate or on the sync edge
    if (ex_v) begin
      if (ex_copy) begin
        st_nxt.hold = st_r.pos;
      end
      if (ex_op == OP_SET_PARAM || ex_op == OP_AUTO) begin
        case (ex_sel)
          SEL_A_NOM: st_nxt.a_nom = ex_val[PAR_W-1:0];
          SEL_V_NOM: st_nxt.v_nom = ex_val[PAR_W-1:0];
          SEL_A_SLD: st_nxt.a_sld = ex_val[SLD_W-1:0];
          SEL_V_SLD: st_nxt.v_sld = ex_val[SLD_W-1:0];
          SEL_JERK: st_nxt.jerk = ex_val[PAR_W-1:0];
          SEL_PRE_DIV: st_nxt.pre_div = ex_pd;
          default: begin
          end
        endcase
      end
      if (ex_op == OP_POS_END) begin
        st_nxt.pos_end = ex_cmd[B1 +: POS_W];
      end else if (ex_op == OP_AUTO) begin
        st_nxt.mode = MRSS_AUTO;
        st_nxt.p_reached = 1'h0;
      end else if (ex_op == OP_CONST) begin
        st_nxt.mode = MRSS_CONST;
        st_nxt.acc = '0;
      end else if (ex_op == OP_LINEAR) begin
        st_nxt.mode = MRSS_LINEAR;
        st_nxt.acc = acc_up;
      end else if (ex_op == OP_SCURVE) begin
        st_nxt.mode = MRSS_SCURVE;
      end
      if (ex_op == OP_AUTO || ex_op == OP_CONST || ex_op == OP_LINEAR || ex_op == OP_SCURVE) begin
        st_nxt.a_reached = 1'h0;
        st_nxt.v_reached = 1'h0;
      end
    end

    // Slowdown; an automatic ramp goes idle, other running modes lose a_sld per tick down to the slowdown velocity
    if (sld_rise && st_r.mode == MRSS_AUTO) begin
      st_nxt.acc = '0;
      st_nxt.vel = '0;
      st_nxt.mode = MRSS_IDLE;
    end else if (sld_act && st_r.mode != MRSS_IDLE && tick) begin
      if (vel_mag > sld_lim) begin
        dec = (vel_mag > a_sld_w) ? (vel_mag - a_sld_w) : '0;
        if (dec < sld_lim) begin
          dec = sld_lim;
        end
        st_nxt.vel = vel_neg ? (~dec + ONE_A) : dec;
        st_nxt.acc = vel_neg ? a_sld_w : (~a_sld_w + ONE_A);
      end
    end

    // Position follows every emitted step
    if (step_o) begin
      st_nxt.pos = dir_o ? (st_r.pos + ONE_P) : (st_r.pos - ONE_P);
    end

    // Stop discards velocity, acceleration and the running segment
    if (stop_hit) begin
      st_nxt.vel = '0;
      st_nxt.acc = '0;
      st_nxt.mode = MRSS_IDLE;
    end

    // Sticky flags; a new event wins over the read clear
    st_nxt.stop_flag = stop_hit || (st_r.stop_flag && !status_rd_i);
    st_nxt.sld_flag = sld_act || (st_r.sld_flag && !status_rd_i);
  end

  // State register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    status_o = '0;
    status_o[ST_A_REACHED] = st_r.a_reached;
    status_o[ST_V_REACHED] = st_r.v_reached;
    status_o[ST_POS_REACHED] = st_r.p_reached;
    status_o[ST_AUTO] = (st_r.mode == MRSS_AUTO);
    status_o[ST_STOP] = st_r.stop_flag;
    status_o[ST_SLD] = st_r.sld_flag;
  end

  assign input_status_o = st_r.pin_s;
  assign seq_enable_o = st_r.seq_en;
  assign seq_sine_o = st_r.sine;
  assign actvel_o = st_r.vel;
  assign actacc_o = st_r.acc;
  assign pos_o = st_r.pos;
  assign hold_pos_o = st_r.hold;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_stop_halts: assert property (
    stop_hit |=> (st_r.vel == '0) && (st_r.mode == MRSS_IDLE))
    else $error("stop did not halt the ramp");

  chk_right_stop_dir: assert property (
    (stop_en_i && vel_fwd && st_r.pin_s[IN_STOP_R]) |=> (st_r.vel == '0) && status_o[ST_STOP])
    else $error("forward motion ignored right stop");

  chk_stop_flag: assert property (
    stop_hit |=> status_o[ST_STOP])
    else $error("stop flag not set");

  chk_sld_decel: assert property (
    (sld_act && tick && st_r.mode != MRSS_AUTO && st_r.mode != MRSS_IDLE && !stop_hit
     && vel_mag > sld_lim && st_r.a_sld != '0) |=> vel_mag < $past(vel_mag))
    else $error("slowdown did not reduce velocity");

  chk_sld_auto_halt: assert property (
    (sld_rise && st_r.mode == MRSS_AUTO && !ex_v) |=> (st_r.mode == MRSS_IDLE) && (st_r.vel == '0))
    else $error("automatic ramp survived slowdown");

  chk_read_clears: assert property (
    (status_rd_i && !stop_hit && !sld_act) |=> !status_o[ST_STOP] && !status_o[ST_SLD])
    else $error("status read did not clear flags");

  chk_sync_capture: assert property (
    (pend_go && ex_copy) |=> (hold_pos_o == $past(st_r.pos)) && !st_r.pend)
    else $error("sync start did not latch position");

  chk_tick_hold: assert property (
    (!tick && !ex_v && !stop_hit && !sld_act) |=> $stable(st_r.acc) && $stable(st_r.vel))
    else $error("integrator moved off tick");

  chk_jerk_add: assert property (
    (tick && st_r.mode == MRSS_SCURVE && !acc_over && !ex_v && !stop_hit && !sld_act)
    |=> st_r.acc == $past(acc_sum_w))
    else $error("jerk not added to acceleration");

  chk_limit_skip: assert property (
    (tick && st_r.mode == MRSS_SCURVE && acc_over && !ex_v && !stop_hit && !sld_act)
    |=> $stable(st_r.acc) && status_o[ST_A_REACHED])
    else $error("addition past nominal not skipped");

  chk_pre_div_load: assert property (
    (ex_v && ex_op == OP_SET_PARAM && ex_sel == SEL_PRE_DIV) |=> st_r.pre_div == $past(ex_pd))
    else $error("pre-divider not loaded");

  chk_step_pos: assert property (
    step_o |=> pos_o == ($past(dir_o) ? ($past(pos_o) + ONE_P) : ($past(pos_o) - ONE_P)))
    else $error("position did not follow step");

  cov_stop_event: cover property (stop_hit);
  cov_sld_auto: cover property (sld_rise && st_r.mode == MRSS_AUTO);
  cov_sync_start: cover property (pend_go && ex_copy);
  cov_auto_done: cover property ((st_r.mode == MRSS_AUTO) ##1 status_o[ST_POS_REACHED]);

endmodule

// File: hw/mrss_step_gen.sv
`timescale 1ns/1ps
module mrss_step_gen #(
  parameter int MAG_W = mrss_pkg::PAR_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Ramp tick and velocity
  input wire logic tick_i,
  input wire logic [MAG_W-1:0] vel_mag_i,
  input wire logic vel_dir_i,
  // Step pulse
  output logic step_o,
  output logic dir_o
);
  import mrss_pkg::*;

  typedef struct packed {
    logic [MAG_W-1:0] phase;
    logic step;
    logic dir;
  } mrss_step_state_t;

  mrss_step_state_t st_r;
  mrss_step_state_t st_nxt;
  logic [MAG_W:0] sum;

  // Phase accumulator; carry out of the top is one step
  always_comb begin
    st_nxt = st_r;
    sum = {1'h0, st_r.phase} + {1'h0, vel_mag_i};
    st_nxt.step = 1'h0;
    if (tick_i) begin
      st_nxt.phase = sum[MAG_W-1:0];
      st_nxt.step = sum[MAG_W];
      st_nxt.dir = vel_dir_i;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step_o = st_r.step;
  assign dir_o = st_r.dir;

  // Magnitude below full scale gives at most one carry per tick
  chk_step_single: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_o |=> !step_o)
    else $error("step pulse longer than one cycle");

endmodule

// File: inc/mrss_pkg.sv
package mrss_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ACC_W = 22;
  localparam int PAR_W = 14;
  localparam int FRAC_W = 8;
  localparam int SLD_W = 13;
  localparam int POS_W = 24;
  localparam int PD_W = 4;
  localparam int TCNT_W = 16;
  localparam int CMD_W = 32;
  localparam int STAT_W = 14;
  localparam int PIN_W = 5;

  // ****************************************
  // Command word layout and codes
  // ****************************************
  localparam int B0 = 0;
  localparam int B1 = 8;
  localparam int B2 = 16;
  localparam int B3 = 24;
  localparam logic [7:0] OP_SET_PARAM = 8'h0A;
  localparam logic [7:0] OP_POS_END = 8'h0E;
  localparam logic [7:0] OP_AUTO = 8'h03;
  localparam logic [7:0] OP_CONST = 8'h01;
  localparam logic [7:0] OP_LINEAR = 8'h02;
  localparam logic [7:0] OP_SCURVE = 8'h04;
  localparam logic [3:0] SEL_A_NOM = 4'h0;
  localparam logic [3:0] SEL_V_NOM = 4'h1;
  localparam logic [3:0] SEL_A_SLD = 4'h4;
  localparam logic [3:0] SEL_V_SLD = 4'h5;
  localparam logic [3:0] SEL_JERK = 4'h6;
  localparam logic [3:0] SEL_PRE_DIV = 4'h7;
  localparam logic [3:0] SEL_NONE = 4'hF;

  // ****************************************
  // Sequencer configuration codes
  // ****************************************
  localparam logic [7:0] SEQ_OFF_B = 8'h00;
  localparam logic [7:0] SEQ_SINE_B0 = 8'h8C;
  localparam logic [7:0] SEQ_SINE_B1 = 8'h05;

  // ****************************************
  // Status and pin bit positions
  // ****************************************
  localparam int ST_A_REACHED = 8;
  localparam int ST_V_REACHED = 9;
  localparam int ST_POS_REACHED = 10;
  localparam int ST_AUTO = 11;
  localparam int ST_STOP = 12;
  localparam int ST_SLD = 13;
  localparam int IN_SLD_R = 0;
  localparam int IN_SLD_L = 1;
  localparam int IN_STOP_R = 2;
  localparam int IN_STOP_L = 3;
  localparam int IN_SYNC = 4;

  localparam logic [FRAC_W-1:0] FRAC_ZERO = 8'h00;

  typedef enum logic [2:0] {
    MRSS_IDLE = 3'b000,
    MRSS_CONST = 3'b001,
    MRSS_LINEAR = 3'b010,
    MRSS_SCURVE = 3'b011,
    MRSS_AUTO = 3'b100
  } mrss_mode_t;

endpackage

// File: testbench/mrss_host_model.sv
`timescale 1ns/1ps
module mrss_host_model (
  // Clock and handshake
  input wire logic core_clk_i,
  input wire logic cmd_ready_i,
  // Queue head
  output logic cmd_valid_o,
  output logic [mrss_pkg::CMD_W-1:0] cmd_data_o,
  output logic cmd_wait_sync_o,
  output logic cmd_copy_hold_o,
  output logic cmd_queue_preempt_o
);
  import mrss_pkg::*;
  logic rdy_s;

  // Ready taken half a period early, so the edge decision never races
  always @(negedge core_clk_i) begin
    rdy_s <= cmd_ready_i;
  end

  // Idle head at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_data_o = 32'h0000_0000;
    cmd_wait_sync_o = 1'b0;
    cmd_copy_hold_o = 1'b0;
    cmd_queue_preempt_o = 1'b0;
  end

  // One command, held until the edge that takes it
  task automatic send(input logic [31:0] data, input logic sync_cmd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_data_o <= data;
    cmd_wait_sync_o <= sync_cmd;
    cmd_copy_hold_o <= sync_cmd;
    cmd_queue_preempt_o <= sync_cmd;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!rdy_s && n < 5000);
    cmd_valid_o <= 1'b0;
    cmd_data_o <= ~data; // Released head shows no stale command
    cmd_wait_sync_o <= 1'b0;
    cmd_copy_hold_o <= 1'b0;
    cmd_queue_preempt_o <= 1'b0;
  endtask

  // Parameter write, value low byte first
  task automatic set_param(input logic [3:0] sel, input logic [15:0] val);
    send({val, 4'h0, sel, OP_SET_PARAM}, 1'b0);
  endtask

  // Target position, least significant byte first
  task automatic target(input logic [23:0] p);
    send({p, OP_POS_END}, 1'b0);
  endtask

  // Automatic ramp, parameters left alone
  task automatic auto_start();
    send({16'h0000, 4'h0, SEL_NONE, OP_AUTO}, 1'b0);
  endtask

  // Plain segment command
  task automatic seg(input logic [7:0] op);
    send({24'h00_0000, op}, 1'b0);
  endtask
endmodule

// File: testbench/mrss_ramp_gen_test.sv
`timescale 1ns/1ps
module mrss_ramp_gen_test;
  import mrss_pkg::*;
  typedef struct {int sel; logic [23:0] exp;} mrss_note_t;
  logic core_clk_i, nrst_i, stop_l_n, stop_r_n, sld_l_n, sld_r_n, sync_in, sld_en, stop_en, status_rd;
  logic cmd_valid, wait_sync, copy_hold, preempt, cmd_ready, seq_en, seq_sine, step, dir;
  logic [31:0] cmd_data;
  logic [7:0] seq0, seq1;
  logic [13:0] status;
  logic [4:0] pin_stat;
  logic [21:0] actvel, actacc;
  logic [23:0] pos, hold_pos, a_nom, base, obs;
  mrss_note_t notes[$];
  event chk_ev;
  int errors, checks_done, seed, steps;

  // ****************************************
  // Design, host and clock
  // ****************************************
  mrss_ramp_gen i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .left_limit_stop_n_i(stop_l_n),
    .right_limit_stop_n_i(stop_r_n), .left_decel_switch_n_i(sld_l_n), .right_decel_switch_n_i(sld_r_n),
    .sync_in_i(sync_in), .stop_en_i(stop_en), .sld_en_i(sld_en), .cmd_valid_i(cmd_valid),
    .cmd_data_i(cmd_data), .cmd_wait_sync_i(wait_sync), .cmd_copy_hold_i(copy_hold),
    .cmd_queue_preempt_i(preempt), .cmd_ready_o(cmd_ready), .seq_cfg0_i(seq0), .seq_cfg1_i(seq1),
    .seq_enable_o(seq_en), .seq_sine_o(seq_sine), .status_rd_i(status_rd), .status_o(status),
    .input_status_o(pin_stat), .step_o(step), .dir_o(dir), .actvel_o(actvel), .actacc_o(actacc),
    .pos_o(pos), .hold_pos_o(hold_pos));
  mrss_host_model i_host (.core_clk_i(core_clk_i), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
    .cmd_data_o(cmd_data), .cmd_wait_sync_o(wait_sync), .cmd_copy_hold_o(copy_hold),
    .cmd_queue_preempt_o(preempt));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Step count is the position the rules predict, all motion runs right
  always @(posedge core_clk_i) begin
    if (step === 1'b1) steps <= steps + 1;
  end

  // ****************************************
  // Result watcher
  // ****************************************
  always @(chk_ev) begin : monitor
    mrss_note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: obs = 24'(status[ST_STOP]);
        1: obs = 24'(status[ST_SLD]);
        2: obs = 24'(actvel);
        3: obs = 24'(actacc);
        4: obs = pos;
        5: obs = hold_pos;
        6: obs = {22'h00_0000, seq_en, seq_sine};
        7: obs = 24'(cmd_ready);
        8: obs = 24'(actvel) - base;
        10: obs = 24'(dir);
        11: obs = 24'(status[ST_AUTO]);
        12: obs = {16'h0000, pin_stat, status[ST_POS_REACHED], status[ST_V_REACHED], status[ST_A_REACHED]};
        default: base = 24'(actvel);
      endcase
      if (n.sel != 9) begin
        checks_done++;
        if (obs !== n.exp) begin
          errors++;
          $display("CHECK FAILED at %0t: item %0d got %0h expected %0h", $time, n.sel, obs, n.exp);
        end
      end
    end
  end

  // ****************************************
  // Driver helpers
  // ****************************************
  task automatic note(input int sel, input logic [23:0] exp);
    mrss_note_t n;
    n.sel = sel;
    n.exp = exp;
    notes.push_back(n);
  endtask
  // Looks at the falling edge, where registered outputs are settled
  task automatic look(input string s);
    @(negedge core_clk_i);
    -> chk_ev;
    $display("test %s done", s);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  task automatic read_status();
    @(posedge core_clk_i) status_rd <= 1'b1;
    @(posedge core_clk_i) status_rd <= 1'b0;
    cyc(2);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog, about fourteen times the expected run
  initial begin
    #1000000;
    errors++;
    final_report();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h4335;
    {errors, checks_done, steps} = '0;
    {stop_l_n, stop_r_n, sld_l_n, sld_r_n, sld_en, stop_en} = 6'h3F;
    {nrst_i, sync_in, status_rd} = 3'h0;
    seq0 = 8'h11;
    seq1 = 8'h22;
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    note(0, 0); note(4, 0); note(7, 1); note(12, 0); look("reset");
    @(posedge core_clk_i) {seq0, seq1} <= {SEQ_OFF_B, SEQ_OFF_B};
    cyc(2); note(6, 0); look("sequencer off");
    @(posedge core_clk_i) {seq0, seq1} <= {SEQ_SINE_B0, SEQ_SINE_B1};
    cyc(2); note(6, 3); look("sequencer sine");
    // Linear segment with a random nominal acceleration, tick every two clocks
    // Floor keeps the cruise speed above the slowdown target
    a_nom = 24'(100 + ($random(seed) & 63));
    i_host.set_param(SEL_PRE_DIV, 16'h0000);
    i_host.set_param(SEL_A_NOM, a_nom[15:0]);
    i_host.set_param(SEL_V_NOM, 16'd2000);
    i_host.set_param(SEL_A_SLD, 16'd1000);
    i_host.set_param(SEL_V_SLD, 16'd100);
    i_host.seg(OP_LINEAR);
    cyc(2); note(3, a_nom << 8); look("linear load");
    cyc(600); note(9, 0); look("velocity mark");
    cyc(8); note(8, a_nom * 4); note(10, 1); look("velocity rate");
    // Wrong-side stop and a disabled slowdown are both ignored
    i_host.seg(OP_CONST);
    @(posedge core_clk_i) {stop_l_n, sld_r_n, sld_en} <= 3'b000;
    cyc(6); note(0, 0); note(1, 0); note(3, 0); look("wrong side stop");
    @(posedge core_clk_i) {stop_l_n, sld_r_n, sld_en} <= 3'b101;
    cyc(400); note(2, 24'd100 << 8); note(1, 1); look("slowdown");
    i_host.seg(OP_CONST);
    @(posedge core_clk_i) sld_r_n <= 1'b1;
    cyc(4); read_status(); note(1, 0); note(2, 24'd100 << 8); look("slowdown clear");
    @(posedge core_clk_i) stop_r_n <= 1'b0;
    cyc(5); note(2, 0); note(3, 0); note(0, 1); look("right stop");
    @(posedge core_clk_i) stop_r_n <= 1'b1;
    cyc(3); note(4, steps); look("step count");
    read_status(); note(0, 0); look("stop clear");
    // Reference capture on the sync edge
    i_host.send({24'h00_0000, OP_CONST}, 1'b1);
    cyc(2); note(7, 0); look("sync parked");
    @(posedge core_clk_i) sync_in <= 1'b1;
    cyc(6); note(7, 1); note(5, steps); look("sync capture");
    @(posedge core_clk_i) sync_in <= 1'b0;
    // Automatic ramp ended by a slowdown switch
    i_host.target(24'h01_1170);
    i_host.auto_start();
    cyc(200); note(11, 1); look("auto run");
    @(posedge core_clk_i) sld_l_n <= 1'b0;
    cyc(5); note(2, 0); note(3, 0); note(11, 0); look("auto slowdown");
    @(posedge core_clk_i) sld_l_n <= 1'b1;
    cyc(2);
    // S-curve with the stop response off, then switched back on
    i_host.set_param(SEL_JERK, 16'd2000);
    @(posedge core_clk_i) {stop_en, stop_r_n} <= 2'b00;
    i_host.seg(OP_SCURVE);
    cyc(100); note(3, 24'((a_nom << 8) / 2000 * 2000)); note(0, 0); note(12, 24'h21); look("s-curve");
    @(posedge core_clk_i) stop_en <= 1'b1;
    cyc(4); note(2, 0); note(0, 1); look("stop enable");
    final_report();
  end
endmodule
